// ==== tsm_pkg.sv ====
package tsm_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic signed [15:0] tsm_sp_t;
  typedef logic [11:0][15:0] tsm_tab_t;
  typedef logic [1:0] tsm_mode_t;
  typedef enum logic [1:0] {ST_ON = 2'b01, ST_OFF = 2'b10} tsm_sw_e;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam logic [4:0] STEP_MIN = 5'h01;
  localparam logic [4:0] STEP_MAX = 5'h14;
  localparam logic [4:0] STEP_DEF = 5'h05;
  localparam tsm_sp_t GAP = 16'sh000a;
  localparam tsm_sp_t SP_LO = -16'sh01f4;
  localparam tsm_sp_t SP_HI = 16'sh03e8;
  localparam int K_OFS = 2731;
  localparam int F_OFS = 320;
  localparam logic [1:0] FMT_C = 2'h0;
  localparam logic [1:0] FMT_K = 2'h1;
  localparam logic [1:0] FMT_F = 2'h2;
  localparam logic [1:0] FMT_STEP = 2'h3;
  localparam tsm_mode_t M_COMF = 2'h0;
  localparam tsm_mode_t M_PROT = 2'h3;
  localparam logic [3:0] IDX_HCOMF = 4'h3;
  localparam logic [3:0] IDX_CCOMF = 4'h4;
  localparam logic [3:0] IDX_HBP = 4'h8;
  localparam logic [3:0] IDX_HFN = 4'h9;
  localparam logic [3:0] IDX_CFN = 4'ha;
  localparam logic [3:0] IDX_CBP = 4'hb;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic DST_RST = 1'b0;
  localparam logic HEAT_RST = 1'b1;
  localparam logic DZ_RST = 1'b1;
  localparam tsm_tab_t SP_RST = {16'h015e, 16'h00f0, 16'h00c8, 16'h0046,
                                 16'h015e, 16'h0118, 16'h0104, 16'h00f0,
                                 16'h00c8, 16'h00b4, 16'h00a0, 16'h0046};

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic tsm_sp_t tsm_get(tsm_tab_t t, logic [3:0] i);
    return tsm_sp_t'(t[i]);
  endfunction : tsm_get

  function automatic tsm_sp_t tsm_sat(tsm_sp_t v, tsm_sp_t lo, tsm_sp_t hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : tsm_sat

  function automatic logic [4:0] tsm_step(logic [4:0] s);
    return (s < STEP_MIN || s > STEP_MAX) ? STEP_DEF : s;
  endfunction : tsm_step

  function automatic tsm_sp_t tsm_bump(tsm_sp_t v, logic up, logic [4:0] s);
    return up ? v + tsm_sp_t'({11'h000, s}) : v - tsm_sp_t'({11'h000, s});
  endfunction : tsm_bump

  function automatic tsm_sp_t tsm_to_c(logic [1:0] f, tsm_sp_t v);
    int t;
    t = int'(v);
    if (f == FMT_K)
      t = t - K_OFS;
    else if (f == FMT_F)
      t = ((t - F_OFS) * 5) / 9;
    return tsm_sat(tsm_sp_t'(t[15:0]), SP_LO, SP_HI);
  endfunction : tsm_to_c

endpackage : tsm_pkg

// ==== tsm_core_if.sv ====
`timescale 1ns/1ps
interface tsm_core_if;
  import tsm_pkg::*;
  tsm_tab_t sp;
  logic [3:0] idx;
  tsm_sp_t val;
  logic dz;
  tsm_sp_t lim;
  logic cfg_load;
  logic cfg_init;
  logic dst_en;
  logic dst_wr;
  logic dst_val;
  logic t_set;
  logic [4:0] t_hour;
  logic [4:0] hour;
  logic dst_state;
  modport core (output sp, idx, val, dz, cfg_load, cfg_init, dst_en, dst_wr, dst_val,
                t_set, t_hour, input lim, hour, dst_state);
  modport clamp (input sp, idx, val, dz, output lim);
  modport dst (input cfg_load, cfg_init, dst_en, dst_wr, dst_val, t_set, t_hour,
               output hour, dst_state);
endinterface : tsm_core_if

// ==== tsm_clamp.sv ====
`timescale 1ns/1ps
module tsm_clamp (
  tsm_core_if.clamp c
);
  import tsm_pkg::*;
  tsm_sp_t lo;
  tsm_sp_t hi;
  tsm_sp_t g34;

  // ----------------------------------------------------------------
  // Neighbour bounds of the written slot
  // ----------------------------------------------------------------
  always_comb
  begin
    g34 = c.dz ? GAP + 16'sh0001 : GAP;
    lo = SP_LO;
    hi = SP_HI;
    case (c.idx)
      4'h0: hi = tsm_get(c.sp, 4'h1);
      4'h1, 4'h2, 4'h5, 4'h6:
      begin
        lo = tsm_get(c.sp, c.idx - 4'h1);
        hi = tsm_get(c.sp, c.idx + 4'h1);
      end
      4'h3:
      begin
        lo = tsm_get(c.sp, 4'h2);
        hi = tsm_get(c.sp, IDX_CCOMF) - g34;
      end
      4'h4:
      begin
        lo = tsm_get(c.sp, IDX_HCOMF) + g34;
        hi = tsm_get(c.sp, 4'h5);
      end
      4'h7: lo = tsm_get(c.sp, 4'h6);
      4'h8: hi = tsm_get(c.sp, IDX_HFN);
      4'h9:
      begin
        lo = tsm_get(c.sp, IDX_HBP);
        if (c.dz)
          hi = tsm_get(c.sp, IDX_CFN) - GAP;
      end
      4'ha:
      begin
        hi = tsm_get(c.sp, IDX_CBP);
        if (c.dz)
          lo = tsm_get(c.sp, IDX_HFN) + GAP;
      end
      4'hb: lo = tsm_get(c.sp, IDX_CFN);
      default: ;
    endcase
  end

  // Out-of-range values are pulled to the nearest bound, never dropped
  assign c.lim = tsm_sat(c.val, lo, hi);

endmodule : tsm_clamp

// ==== tsm_dst.sv ====
`timescale 1ns/1ps
module tsm_dst (
  input wire logic clk,
  input wire logic rst_n,
  tsm_core_if.dst d
);
  import tsm_pkg::*;
  typedef struct packed {
    logic state;
    logic [4:0] hour;
  } tsm_dst_s;
  tsm_dst_s r;
  tsm_dst_s next_r;

  // ----------------------------------------------------------------
  // Daylight-saving tracking
  // ----------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    if (d.cfg_load)
      next_r.state = d.cfg_init;
    else if (d.dst_en && d.dst_wr && d.dst_val != r.state)
    begin
      next_r.state = d.dst_val;
      if (d.dst_val)
        next_r.hour = (r.hour == HOUR_MAX) ? 5'h00 : r.hour + 5'h01;
      else
        next_r.hour = (r.hour == 5'h00) ? HOUR_MAX : r.hour - 5'h01;
    end
    // A time set wins over any offset in the same cycle
    if (d.t_set)
      next_r.hour = d.t_hour;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '{state: DST_RST, hour: 5'h00};
    else
      r <= next_r;
  end

  assign d.hour = r.hour;
  assign d.dst_state = r.state;

  a_dst_forward: assert property (@(posedge clk) disable iff (!rst_n)
    (d.dst_en && d.dst_wr && d.dst_val && !r.state && !d.t_set && !d.cfg_load)
    |=> (r.state && r.hour == (($past(r.hour) == HOUR_MAX) ? 5'h00 : $past(r.hour) + 5'h01)))
    else $error("hour not advanced on daylight-saving entry");
  a_dst_repeat: assert property (@(posedge clk) disable iff (!rst_n)
    (d.dst_wr && d.dst_val == r.state && !d.t_set && !d.cfg_load) |=> $stable(r.hour))
    else $error("hour moved on repeated status");
  a_time_exact: assert property (@(posedge clk) disable iff (!rst_n)
    d.t_set |=> r.hour == $past(d.t_hour))
    else $error("set time was altered");

endmodule : tsm_dst

// ==== tsm_setpoint_mgr.sv ====
`timescale 1ns/1ps
module tsm_setpoint_mgr #(
  parameter tsm_pkg::tsm_sp_t LOCAL_LIM = 16'sh0014
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CTRL_SETPOINT,
  input wire logic SLAVE,
  input wire logic [4:0] CFG_STEP,
  input wire logic [4:0] CFG_FORCE_STEP,
  input wire logic MODE_SP_EN,
  input wire logic MODE_SP_WR,
  input wire logic [2:0] MODE_SP_IDX,
  input wire logic [1:0] MODE_SP_FMT,
  input wire tsm_pkg::tsm_sp_t MODE_SP_VAL,
  input wire logic FUNC_SP_WR,
  input wire logic [1:0] FUNC_SP_FMT,
  input wire tsm_pkg::tsm_sp_t FUNC_SP_VAL,
  input wire logic FORCE_EN,
  input wire logic FORCE_WR,
  input wire logic FORCE_UP,
  input wire logic LOCAL_STEP,
  input wire logic LOCAL_UP,
  input wire logic MODE_KEY,
  input wire logic HVAC_WR,
  input wire tsm_pkg::tsm_mode_t HVAC_VAL,
  input wire logic LSO_EN,
  input wire logic REACT_REMOTE,
  input wire logic FT_EN,
  input wire logic FT_WR,
  input wire logic FT_HEAT,
  input wire logic LOCAL_FT_WR,
  input wire logic LOCAL_FT_HEAT,
  input wire logic DZ_AUTO,
  input wire logic AUTO_HEAT,
  input wire logic DZ_WR,
  input wire logic DZ_ENABLE,
  input wire logic DST_EN,
  input wire logic DST_WR,
  input wire logic DST_VAL,
  input wire logic CFG_LOAD,
  input wire logic CFG_DST_INIT,
  input wire logic TIME_SET,
  input wire logic [4:0] TIME_HOUR,
  output logic [191:0] SP_TABLE,
  output tsm_pkg::tsm_sp_t CUR_SP,
  output tsm_pkg::tsm_mode_t HVAC_MODE,
  output logic HEATING,
  output logic DZ_ACTIVE,
  output logic SWITCHED_OFF,
  output logic PENDING,
  output logic [4:0] HOUR,
  output logic DST_STATE
);
  import tsm_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    tsm_tab_t sp;
    tsm_sw_e st;
    tsm_mode_t mode;
    tsm_mode_t hvac;
    logic pm_v;
    tsm_mode_t pm;
    logic ps_v;
    tsm_sp_t ps;
    tsm_sp_t master;
    tsm_sp_t foff;
    tsm_sp_t cur;
    logic heat;
    logic dz;
    logic slave;
  } tsm_main_s;

  tsm_main_s r;
  tsm_main_s next_r;
  tsm_core_if cif ();

  logic [4:0] step;
  logic [4:0] fstep;
  logic [3:0] fn_idx;
  logic [3:0] cur_idx;
  logic [3:0] wr_idx;
  tsm_sp_t fn_cur;
  tsm_sp_t fn_val;
  tsm_sp_t wr_val;
  tsm_sp_t loc_val;
  tsm_mode_t eff_mode;
  logic wr;
  logic remote_sp;
  logic remote_mode;
  logic can_off;
  logic hold;
  logic end_off;

  tsm_clamp u_clamp (
    .c (cif.clamp)
  );

  tsm_dst u_dst (
    .clk (REF_CLK),
    .rst_n (RST_N),
    .d (cif.dst)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    step = tsm_step(CFG_STEP);
    fstep = tsm_step(CFG_FORCE_STEP);
    fn_idx = r.heat ? IDX_HFN : IDX_CFN;
    fn_cur = tsm_get(r.sp, fn_idx);
    fn_val = (FUNC_SP_FMT == FMT_STEP) ? tsm_bump(fn_cur, FUNC_SP_VAL[0], step)
                                       : tsm_to_c(FUNC_SP_FMT, FUNC_SP_VAL);
    remote_sp = FUNC_SP_WR && CTRL_SETPOINT;
    remote_mode = HVAC_WR && !CTRL_SETPOINT;
    can_off = (SLAVE && LSO_EN) || (!SLAVE && CTRL_SETPOINT);

    // Switch-off machine
    case (r.st)
      ST_ON:
        if (MODE_KEY && can_off)
          next_r.st = ST_OFF;
      ST_OFF:
        if (MODE_KEY || (REACT_REMOTE && (remote_sp || remote_mode)))
          next_r.st = ST_ON;
      default: next_r.st = ST_ON;
    endcase
    next_r.slave = SLAVE;
    if (SLAVE != r.slave)
      next_r.st = ST_ON;
    hold = (next_r.st == ST_OFF);
    end_off = (r.st == ST_OFF) && (next_r.st == ST_ON);

    // Operating mode
    if (remote_mode && hold)
    begin
      next_r.pm_v = 1'b1;
      next_r.pm = HVAC_VAL;
    end
    else if (remote_mode)
    begin
      next_r.mode = HVAC_VAL;
      next_r.pm_v = 1'b0;
    end
    else if (end_off && r.pm_v)
    begin
      next_r.mode = r.pm;
      next_r.pm_v = 1'b0;
    end
    else if (MODE_KEY && r.st == ST_ON && !can_off && !SLAVE && !CTRL_SETPOINT)
      next_r.mode = r.mode + 2'h1;

    // Single setpoint write per cycle, checked by the clamp
    wr = 1'b0;
    wr_idx = fn_idx;
    wr_val = fn_val;
    loc_val = tsm_bump(tsm_get(r.sp, cur_sel(r.st, r.mode, r.heat)), LOCAL_UP, step);
    if (SLAVE && CTRL_SETPOINT)
      loc_val = tsm_sat(loc_val, r.master - LOCAL_LIM, r.master + LOCAL_LIM);
    if (remote_sp && hold)
    begin
      next_r.ps_v = 1'b1;
      next_r.ps = fn_val;
      next_r.master = fn_val;
    end
    else if (remote_sp)
    begin
      wr = 1'b1;
      next_r.master = fn_val;
      next_r.ps_v = 1'b0;
    end
    else if (end_off && r.ps_v)
    begin
      wr = 1'b1;
      wr_val = r.ps;
      next_r.ps_v = 1'b0;
    end
    else if (MODE_SP_WR && MODE_SP_EN)
    begin
      wr = 1'b1;
      wr_idx = {1'b0, MODE_SP_IDX};
      wr_val = (MODE_SP_FMT == FMT_STEP)
               ? tsm_bump(tsm_get(r.sp, wr_idx), MODE_SP_VAL[0], step)
               : tsm_to_c(MODE_SP_FMT, MODE_SP_VAL);
    end
    else if (LOCAL_STEP && r.st == ST_ON)
    begin
      wr = 1'b1;
      wr_idx = cur_sel(r.st, r.mode, r.heat);
      wr_val = loc_val;
    end
    if (wr)
      next_r.sp[wr_idx] = cif.lim;

    // Temporary forcing is dropped when the feature is turned off
    if (!FORCE_EN)
      next_r.foff = 16'sh0000;
    else if (FORCE_WR)
      next_r.foff = tsm_sat(tsm_bump(r.foff, FORCE_UP, fstep), SP_LO, SP_HI);

    // Heat/cool selection and dead zone
    if (DZ_AUTO && DZ_WR)
      next_r.dz = DZ_ENABLE;
    if (FT_EN && FT_WR)
      next_r.heat = FT_HEAT;
    else if (LOCAL_FT_WR)
      next_r.heat = LOCAL_FT_HEAT;
    else if (DZ_AUTO && r.dz)
      next_r.heat = AUTO_HEAT;

    eff_mode = hold ? M_PROT : next_r.mode;
    next_r.hvac = eff_mode;
    // Next mode and heat pick the slot, so the output follows a change at once
    cur_idx = cur_sel(next_r.st, next_r.mode, next_r.heat);
    // Forcing result is saturated to the global range only
    next_r.cur = tsm_sat(tsm_get(next_r.sp, cur_idx) + next_r.foff, SP_LO, SP_HI);
  end

  // Slot that supplies the current setpoint for a given switch state
  function automatic logic [3:0] cur_sel(tsm_sw_e s, tsm_mode_t md, logic ht);
    tsm_mode_t m;
    m = (s == ST_OFF) ? M_PROT : md;
    if (CTRL_SETPOINT)
      return ht ? ((s == ST_OFF) ? IDX_HBP : IDX_HFN)
                : ((s == ST_OFF) ? IDX_CBP : IDX_CFN);
    return ht ? IDX_HCOMF - {2'h0, m} : IDX_CCOMF + {2'h0, m};
  endfunction : cur_sel

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      r <= '{sp: SP_RST, st: ST_ON, mode: M_COMF, hvac: M_COMF, pm_v: 1'b0, pm: M_COMF,
             ps_v: 1'b0, ps: 16'sh0000, master: tsm_sp_t'(SP_RST[IDX_HFN]),
             foff: 16'sh0000, cur: tsm_sp_t'(SP_RST[IDX_HCOMF]), heat: HEAT_RST,
             dz: DZ_RST, slave: 1'b0};
    else
      r <= next_r;
  end

  // ----------------------------------------------------------------
  // Helper connections
  // ----------------------------------------------------------------
  assign cif.sp = r.sp;
  assign cif.idx = wr_idx;
  assign cif.val = wr_val;
  assign cif.dz = DZ_AUTO && r.dz;
  assign cif.cfg_load = CFG_LOAD;
  assign cif.cfg_init = CFG_DST_INIT;
  assign cif.dst_en = DST_EN;
  assign cif.dst_wr = DST_WR;
  assign cif.dst_val = DST_VAL;
  assign cif.t_set = TIME_SET;
  assign cif.t_hour = TIME_HOUR;

  assign SP_TABLE = r.sp;
  assign CUR_SP = r.cur;
  assign HVAC_MODE = r.hvac;
  assign HEATING = r.heat;
  assign DZ_ACTIVE = DZ_AUTO && r.dz;
  assign SWITCHED_OFF = (r.st == ST_OFF);
  assign PENDING = r.pm_v || r.ps_v;
  assign HOUR = cif.hour;
  assign DST_STATE = cif.dst_state;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_heat_order: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    tsm_get(r.sp, 4'h0) <= tsm_get(r.sp, 4'h1) && tsm_get(r.sp, 4'h1) <= tsm_get(r.sp, 4'h2)
    && tsm_get(r.sp, 4'h2) <= tsm_get(r.sp, 4'h3) && tsm_get(r.sp, 4'h4) <= tsm_get(r.sp, 4'h5)
    && tsm_get(r.sp, 4'h5) <= tsm_get(r.sp, 4'h6) && tsm_get(r.sp, 4'h6) <= tsm_get(r.sp, 4'h7))
    else $error("mode setpoint order broken");
  a_comfort_gap: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    tsm_get(r.sp, IDX_HCOMF) <= tsm_get(r.sp, IDX_CCOMF) - GAP)
    else $error("comfort gap broken");
  a_sp_order: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    tsm_get(r.sp, IDX_HBP) <= tsm_get(r.sp, IDX_HFN)
    && tsm_get(r.sp, IDX_CFN) <= tsm_get(r.sp, IDX_CBP))
    else $error("protection order broken");
  a_step_raise: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (wr && remote_sp && FUNC_SP_FMT == FMT_STEP && FUNC_SP_VAL[0] && cif.lim == fn_val)
    |=> tsm_get(r.sp, $past(fn_idx)) == $past(fn_cur) + tsm_sp_t'({11'h000, $past(step)}))
    else $error("step did not raise setpoint");
  a_force_clear: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !FORCE_EN |=> r.foff == 16'sh0000)
    else $error("forcing kept while disabled");
  a_slave_block: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (SLAVE && r.slave && !CTRL_SETPOINT && MODE_KEY && !HVAC_WR && r.st == ST_ON)
    |=> r.mode == $past(r.mode))
    else $error("slave mode changed locally");
  a_queue_hold: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (r.st == ST_OFF && !REACT_REMOTE && !MODE_KEY && SLAVE == r.slave && remote_mode)
    |=> (SWITCHED_OFF && r.pm_v && r.mode == $past(r.mode)))
    else $error("remote mode not queued");
  a_remote_wake: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (r.st == ST_OFF && REACT_REMOTE && remote_mode)
    |=> (!SWITCHED_OFF && HVAC_MODE == $past(HVAC_VAL)))
    else $error("remote change did not wake");
  a_mode_cancel: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (SLAVE != r.slave) |=> !SWITCHED_OFF)
    else $error("switch-off survived operation change");
  a_key_off: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (!SLAVE && !r.slave && CTRL_SETPOINT && MODE_KEY && r.st == ST_ON)
    |=> (SWITCHED_OFF ##1 CUR_SP == tsm_sat(tsm_get(r.sp, r.heat ? IDX_HBP : IDX_CBP)
    + r.foff, SP_LO, SP_HI)) or (SWITCHED_OFF ##1 !SWITCHED_OFF))
    else $error("mode key did not switch off");

endmodule : tsm_setpoint_mgr

// ==== tsm_bus_peer.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Remote bus devices: master thermostat and supervisor
// ------------------------------------------------------------
module tsm_bus_peer (
  input wire logic clk,
  output logic FUNC_SP_WR,
  output logic [1:0] FUNC_SP_FMT,
  output tsm_pkg::tsm_sp_t FUNC_SP_VAL,
  output logic HVAC_WR,
  output tsm_pkg::tsm_mode_t HVAC_VAL,
  output logic DST_WR,
  output logic DST_VAL
);
  import tsm_pkg::*;
  initial
  begin
    {FUNC_SP_WR, FUNC_SP_FMT, FUNC_SP_VAL, HVAC_WR, HVAC_VAL, DST_WR, DST_VAL} = '0;
  end
  // A telegram is taken on one edge; value lines then scramble, so a stale value is never trusted
  task automatic func(input logic [1:0] f, input tsm_sp_t v);
    FUNC_SP_FMT = f;
    FUNC_SP_VAL = v;
    FUNC_SP_WR = 1'b1;
    @(negedge clk);
    FUNC_SP_WR = 1'b0;
    FUNC_SP_VAL = ~v;
    @(negedge clk);
  endtask : func
  task automatic hvac(input tsm_mode_t m);
    HVAC_VAL = m;
    HVAC_WR = 1'b1;
    @(negedge clk);
    HVAC_WR = 1'b0;
    HVAC_VAL = ~m;
    @(negedge clk);
  endtask : hvac
  task automatic dst(input logic v);
    DST_VAL = v;
    DST_WR = 1'b1;
    @(negedge clk);
    DST_WR = 1'b0;
    DST_VAL = ~v;
    @(negedge clk);
  endtask : dst
endmodule : tsm_bus_peer

// ==== tsm_setpoint_mgr_tb_top.sv ====
`timescale 1ns/1ps
module tsm_setpoint_mgr_tb_top;
  import tsm_pkg::*;
  logic REF_CLK = 1'b0;
  logic RST_N, CTRL_SETPOINT, SLAVE, MODE_SP_EN, MODE_SP_WR, FUNC_SP_WR, FORCE_EN, FORCE_WR;
  logic FORCE_UP, LOCAL_STEP, LOCAL_UP, MODE_KEY, HVAC_WR, LSO_EN, REACT_REMOTE, FT_EN, FT_WR;
  logic FT_HEAT, LOCAL_FT_WR, LOCAL_FT_HEAT, DZ_AUTO, AUTO_HEAT, DZ_WR, DZ_ENABLE, DST_EN;
  logic DST_WR, DST_VAL, CFG_LOAD, CFG_DST_INIT, TIME_SET, HEATING, DZ_ACTIVE, SWITCHED_OFF;
  logic PENDING, DST_STATE;
  logic [4:0] CFG_STEP, CFG_FORCE_STEP, TIME_HOUR, HOUR;
  logic [2:0] MODE_SP_IDX;
  logic [1:0] MODE_SP_FMT, FUNC_SP_FMT;
  tsm_sp_t MODE_SP_VAL, FUNC_SP_VAL, CUR_SP, e;
  tsm_mode_t HVAC_VAL, HVAC_MODE;
  logic [191:0] SP_TABLE;
  logic [31:0] x = 32'h000129ad;
  logic [31:0] r;
  int bad_count = 0;
  int n_compared = 0;
  tsm_sp_t rt [12] = '{16'sh0046, 16'sh00a0, 16'sh00b4, 16'sh00c8, 16'sh00f0, 16'sh0104,
                       16'sh0118, 16'sh015e, 16'sh0046, 16'sh00c8, 16'sh00f0, 16'sh015e};

  always #5 REF_CLK = ~REF_CLK;

  tsm_setpoint_mgr dut_u (.REF_CLK, .RST_N, .CTRL_SETPOINT, .SLAVE, .CFG_STEP, .CFG_FORCE_STEP,
    .MODE_SP_EN, .MODE_SP_WR, .MODE_SP_IDX, .MODE_SP_FMT, .MODE_SP_VAL, .FUNC_SP_WR,
    .FUNC_SP_FMT, .FUNC_SP_VAL, .FORCE_EN, .FORCE_WR, .FORCE_UP, .LOCAL_STEP, .LOCAL_UP,
    .MODE_KEY, .HVAC_WR, .HVAC_VAL, .LSO_EN, .REACT_REMOTE, .FT_EN, .FT_WR, .FT_HEAT,
    .LOCAL_FT_WR, .LOCAL_FT_HEAT, .DZ_AUTO, .AUTO_HEAT, .DZ_WR, .DZ_ENABLE, .DST_EN, .DST_WR,
    .DST_VAL, .CFG_LOAD, .CFG_DST_INIT, .TIME_SET, .TIME_HOUR, .SP_TABLE, .CUR_SP, .HVAC_MODE,
    .HEATING, .DZ_ACTIVE, .SWITCHED_OFF, .PENDING, .HOUR, .DST_STATE);

  tsm_bus_peer peer_u (.clk(REF_CLK), .FUNC_SP_WR, .FUNC_SP_FMT, .FUNC_SP_VAL, .HVAC_WR,
    .HVAC_VAL, .DST_WR, .DST_VAL);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xs
  function automatic tsm_sp_t sl(input int i);
    return tsm_sp_t'(SP_TABLE[16*i +: 16]);
  endfunction : sl
  // Out-of-range step settings fall back to the default step
  function automatic tsm_sp_t eff(input logic [4:0] s);
    return (s == 5'h00 || s > 5'h14) ? 16'sh0005 : tsm_sp_t'({11'h000, s});
  endfunction : eff
  // Heating functioning window: building protection up to cooling minus the dead-zone gap
  function automatic tsm_sp_t lim(input tsm_sp_t v);
    return (v < 16'sh0046) ? 16'sh0046 : ((v > 16'sh00e6) ? 16'sh00e6 : v);
  endfunction : lim
  task automatic chk_sp(input tsm_sp_t g, input tsm_sp_t ex);
    n_compared++;
    if (g !== ex)
    begin
      bad_count++;
      $display("[ERR] %0t setpoint got %0d exp %0d", $time, g, ex);
    end
  endtask : chk_sp
  task automatic chk_b(input logic [4:0] g, input logic [4:0] ex);
    n_compared++;
    if (g !== ex)
    begin
      bad_count++;
      $display("[ERR] %0t status got %0d exp %0d", $time, g, ex);
    end
  endtask : chk_b
  // Strobes drop one edge after they rise, with an idle edge so they never rise again at once
  task automatic nx();
    @(negedge REF_CLK);
    {MODE_SP_WR, FORCE_WR, LOCAL_STEP, MODE_KEY, FT_WR, LOCAL_FT_WR, DZ_WR, CFG_LOAD,
     TIME_SET} = '0;
    @(negedge REF_CLK);
  endtask : nx
  task automatic msp(input logic [2:0] i, input logic [1:0] f, input tsm_sp_t v);
    {MODE_SP_IDX, MODE_SP_FMT, MODE_SP_VAL} = {i, f, v};
    MODE_SP_WR = 1'b1;
    nx();
  endtask : msp
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  initial
  begin
    #50000;
    bad_count++;
    wrap_up();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {RST_N, SLAVE, MODE_SP_WR, MODE_SP_IDX, MODE_SP_FMT, MODE_SP_VAL, FORCE_EN, FORCE_WR,
     FORCE_UP, LOCAL_STEP, LOCAL_UP, MODE_KEY, LSO_EN, REACT_REMOTE, FT_WR, FT_HEAT,
     LOCAL_FT_WR, LOCAL_FT_HEAT, DZ_WR, DZ_ENABLE, CFG_LOAD, CFG_DST_INIT, TIME_SET,
     TIME_HOUR} = '0;
    {CTRL_SETPOINT, MODE_SP_EN, FT_EN, DZ_AUTO, AUTO_HEAT, DST_EN} = 6'h3f;
    CFG_STEP = 5'h05;
    CFG_FORCE_STEP = 5'h05;
    repeat (3) @(posedge REF_CLK);
    @(negedge REF_CLK);
    RST_N = 1'b1;
    for (int i = 0; i < 12; i++)
      chk_sp(sl(i), rt[i]);
    chk_b(HOUR, 5'h00);
    chk_b({4'h0, DST_STATE}, 5'h00);
    peer_u.func(FMT_C, 16'sh012c);
    chk_sp(sl(9), 16'sh00e6);
    peer_u.func(FMT_C, 16'sh0000);
    chk_sp(sl(9), 16'sh0046);
    peer_u.func(FMT_K, 16'sh0b82);
    chk_sp(sl(9), 16'sh00d7);
    peer_u.func(FMT_F, 16'sh02a8);
    chk_sp(sl(9), 16'sh00c8);
    e = 16'sh00c8;
    repeat (16)
    begin
      r = xs();
      if (r[0])
      begin
        e = tsm_sp_t'(16'h0050 + 16'(r[15:8] % 8'h8c));
        peer_u.func(FMT_C, e);
      end
      else
      begin
        CFG_STEP = r[8:4];
        e = lim(r[1] ? e + eff(r[8:4]) : e - eff(r[8:4]));
        peer_u.func(FMT_STEP, {15'h0000, r[1]});
      end
      chk_sp(sl(9), e);
      chk_sp(CUR_SP, e);
    end
    {FORCE_EN, FORCE_UP, FORCE_WR} = 3'h7;
    CFG_FORCE_STEP = 5'h03;
    nx();
    chk_sp(CUR_SP, e + 16'sh0003);
    {FORCE_UP, FORCE_WR} = 2'h1;
    @(negedge REF_CLK);
    nx();
    chk_sp(CUR_SP, e - 16'sh0003);
    FORCE_EN = 1'b0;
    nx();
    chk_sp(CUR_SP, e);
    MODE_KEY = 1'b1;
    nx();
    chk_b({4'h0, SWITCHED_OFF}, 5'h01);
    chk_sp(CUR_SP, 16'sh0046);
    peer_u.func(FMT_C, 16'sh00d2);
    chk_b({4'h0, PENDING}, 5'h01);
    chk_sp(sl(9), e);
    MODE_KEY = 1'b1;
    nx();
    chk_sp(sl(9), 16'sh00d2);
    chk_b({3'h0, SWITCHED_OFF, PENDING}, 5'h00);
    REACT_REMOTE = 1'b1;
    MODE_KEY = 1'b1;
    nx();
    peer_u.func(FMT_C, 16'sh00be);
    chk_sp(sl(9), 16'sh00be);
    chk_b({4'h0, SWITCHED_OFF}, 5'h00);
    MODE_KEY = 1'b1;
    nx();
    SLAVE = 1'b1;
    nx();
    chk_b({4'h0, SWITCHED_OFF}, 5'h00);
    CFG_STEP = 5'h05;
    peer_u.func(FMT_C, 16'sh0096);
    {LOCAL_UP, LOCAL_STEP} = 2'h3;
    repeat (5) @(negedge REF_CLK);
    nx();
    chk_sp(sl(9), 16'sh00aa);
    {LOCAL_UP, LOCAL_STEP} = 2'h1;
    nx();
    chk_sp(sl(9), 16'sh00a5);
    CTRL_SETPOINT = 1'b0;
    peer_u.hvac(2'h2);
    MODE_KEY = 1'b1;
    nx();
    chk_b({3'h0, HVAC_MODE}, 5'h02);
    LSO_EN = 1'b1;
    MODE_KEY = 1'b1;
    nx();
    chk_b({2'h0, HVAC_MODE, SWITCHED_OFF}, 5'h07);
    peer_u.hvac(2'h1);
    chk_b({2'h0, HVAC_MODE, SWITCHED_OFF}, 5'h02);
    REACT_REMOTE = 1'b0;
    MODE_KEY = 1'b1;
    nx();
    peer_u.hvac(2'h2);
    chk_b({1'h0, HVAC_MODE, SWITCHED_OFF, PENDING}, 5'h0f);
    MODE_KEY = 1'b1;
    nx();
    chk_b({1'h0, HVAC_MODE, SWITCHED_OFF, PENDING}, 5'h08);
    msp(3'h3, FMT_C, 16'sh012c);
    chk_sp(sl(3), 16'sh00e5);
    msp(3'h0, FMT_C, 16'sh01f4);
    chk_sp(sl(0), 16'sh00a0);
    msp(3'h7, FMT_C, 16'sh0000);
    chk_sp(sl(7), 16'sh0118);
    msp(3'h1, FMT_STEP, 16'sh0001);
    chk_sp(sl(1), 16'sh00a5);
    MODE_SP_EN = 1'b0;
    msp(3'h1, FMT_C, 16'sh00aa);
    chk_sp(sl(1), 16'sh00a5);
    AUTO_HEAT = 1'b0;
    nx();
    chk_b({4'h0, HEATING}, 5'h00);
    DZ_WR = 1'b1;
    nx();
    AUTO_HEAT = 1'b1;
    nx();
    chk_b({3'h0, DZ_ACTIVE, HEATING}, 5'h00);
    {FT_HEAT, FT_WR} = 2'h3;
    nx();
    chk_b({4'h0, HEATING}, 5'h01);
    LOCAL_FT_WR = 1'b1;
    nx();
    chk_b({4'h0, HEATING}, 5'h00);
    {LOCAL_FT_HEAT, LOCAL_FT_WR} = 2'h3;
    nx();
    chk_b({4'h0, HEATING}, 5'h01);
    {FT_HEAT, FT_EN, FT_WR} = 3'h1;
    nx();
    chk_b({4'h0, HEATING}, 5'h01);
    MODE_SP_EN = 1'b1;
    msp(3'h3, FMT_C, 16'sh012c);
    chk_sp(sl(3), 16'sh00e6);
    {AUTO_HEAT, DZ_ENABLE, DZ_WR} = 3'h3;
    nx();
    chk_b({3'h0, DZ_ACTIVE, HEATING}, 5'h02);
    msp(3'h3, FMT_C, 16'sh012c);
    chk_sp(sl(3), 16'sh00e5);
    DZ_AUTO = 1'b0;
    msp(3'h3, FMT_C, 16'sh012c);
    chk_sp(sl(3), 16'sh00e6);
    chk_b({4'h0, DZ_ACTIVE}, 5'h00);
    DZ_AUTO = 1'b1;
    peer_u.dst(1'b1);
    chk_b({DST_STATE, HOUR[3:0]}, 5'h11);
    peer_u.dst(1'b1);
    chk_b(HOUR, 5'h01);
    peer_u.dst(1'b0);
    chk_b({DST_STATE, HOUR[3:0]}, 5'h00);
    {TIME_SET, TIME_HOUR} = {1'b1, 5'h17};
    nx();
    chk_b(HOUR, 5'h17);
    peer_u.dst(1'b1);
    chk_b(HOUR, 5'h00);
    {TIME_SET, TIME_HOUR} = {1'b1, 5'h05};
    nx();
    chk_b(HOUR, 5'h05);
    {CFG_DST_INIT, CFG_LOAD} = 2'h3;
    nx();
    chk_b({DST_STATE, HOUR[3:0]}, 5'h15);
    DST_EN = 1'b0;
    peer_u.dst(1'b0);
    chk_b({DST_STATE, HOUR[3:0]}, 5'h15);
    wrap_up();
  end
endmodule : tsm_setpoint_mgr_tb_top
